// ### rtl/pwmpt_pkg.sv
// Constants, register map and field layout of the PWM generator with period timer.
package pwmpt_pkg;

  localparam logic [11:0] ADDR_TIMER_CTRL = 12'h000;
  localparam logic [11:0] ADDR_HW_LIMIT = 12'h004;
  localparam logic [11:0] ADDR_TIMER_COUNT = 12'h008;
  localparam logic [11:0] ADDR_PERIOD = 12'h00c;
  localparam logic [11:0] ADDR_WAVE_CTRL = 12'h010;
  localparam logic [11:0] ADDR_DUTY_LOW = 12'h014;
  localparam logic [11:0] ADDR_DUTY_HIGH = 12'h018;
  localparam logic [11:0] ADDR_PIN_CTRL = 12'h01c;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h020;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h024;

  // Timer control register fields.
  localparam int TC_ON_BIT = 7;
  localparam int TC_PRESCALE_SELECT_LSB = 4;
  localparam int TC_SRC_BIT = 0;

  // Hardware limit control register fields.
  localparam int HL_PRESCALER_SYNC_ENABLE_BIT = 7;
  localparam int HL_CLOCK_EDGE_SELECT_BIT = 6;
  localparam int HL_ON_BIT_SYNC_ENABLE_BIT = 5;
  localparam logic [4:0] MODE_FREE_RUN = 5'h00;
  localparam logic [4:0] MODE_ONE_SHOT = 5'h08;

  // Waveform control register fields.
  localparam int WC_EN_BIT = 7;
  localparam int WC_OUT_BIT = 5;
  localparam int WC_POL_BIT = 4;

  // Pin control register fields.
  localparam int PC_DIR_BIT = 0;
  localparam int PC_SEL_LSB = 8;
  localparam logic [5:0] PIN_ROUTE_PWM = 6'h01;

  // Reset values.
  localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
  localparam logic [7:0] RST_HW_LIMIT = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_DUTY_HIGH = 8'h00;
  localparam logic [1:0] RST_DUTY_LOW = 2'h0;
  localparam logic RST_PIN_DIR = 1'b1;
  localparam logic [5:0] RST_PIN_SEL = 6'h00;

  // Instruction clock is the system clock divided by four.
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

endpackage : pwmpt_pkg

// ### rtl/pwmpt_prescaler.sv
// Timer prescaler dividing the timer input clock by one to 128.
`timescale 1ns/1ns
`default_nettype none
module pwmpt_prescaler import pwmpt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clear,
  input wire logic [2:0] sel,
  output logic pulse,
  output logic [1:0] frac
);

  typedef struct packed {
    logic [6:0] cnt;
  } pwmpt_pre_t;

  pwmpt_pre_t st_ff;
  pwmpt_pre_t nxt_st;
  logic [6:0] mask;
  logic [6:0] shifted;

  assign mask = 7'((8'h01 << sel) - 8'h01);
  assign pulse = tick && ((st_ff.cnt & mask) == mask);
  assign shifted = st_ff.cnt >> (sel - 3'h2);

  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st.cnt = 7'h00;
    end else if (tick) begin
      nxt_st.cnt = pulse ? 7'h00 : 7'(st_ff.cnt + 7'h01);
    end
  end

  // The two fraction bits extend the 8-bit count to the 10-bit duty compare.
  always_comb begin
    case (sel)
      3'h0: frac = 2'h0;
      3'h1: frac = {st_ff.cnt[0], 1'b0};
      default: frac = shifted[1:0];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : pwmpt_prescaler
`default_nettype wire

// ### rtl/pwmpt_sync2.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ns
`default_nettype none
module pwmpt_sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pwmpt_sync_t;

  pwmpt_sync_t st_ff;
  pwmpt_sync_t nxt_st;

  always_comb begin
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.s2;

endmodule : pwmpt_sync2
`default_nettype wire

// ### rtl/pwmpt_top.sv
// PWM generator on a period timer with an APB register slave.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pwmpt_top import pwmpt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic ext_clk_in,
  output logic pwm_pin_out,
  output logic pwm_pin_oe_n,
  output logic irq
);

  typedef struct packed {
    logic [31:0] rdata;
    logic slverr;
    logic tmr_on;
    logic [2:0] prescale_select;
    logic clk_src;
    logic [7:0] hlt;
    logic [7:0] count;
    logic [7:0] period;
    logic pwm_en;
    logic pwm_pol;
    logic [1:0] dcl;
    logic [7:0] dch;
    logic pin_dir;
    logic [5:0] pin_sel;
    logic sts;
    logic msk;
    logic [1:0] div;
    logic lvl_prev;
    logic [1:0] on_sh;
    logic pend;
    logic [9:0] duty_sh;
    logic pwm_state;
    logic wrap_d;
    logic pin_val;
    logic irq;
  } pwmpt_state_t;

  localparam pwmpt_state_t ST_RST = '{
    rdata: 32'h0000_0000,
    slverr: 1'b0,
    tmr_on: RST_TIMER_CTRL[TC_ON_BIT],
    prescale_select: RST_TIMER_CTRL[TC_PRESCALE_SELECT_LSB +: 3],
    clk_src: RST_TIMER_CTRL[TC_SRC_BIT],
    hlt: RST_HW_LIMIT,
    count: RST_COUNT,
    period: RST_PERIOD,
    pwm_en: 1'b0,
    pwm_pol: 1'b0,
    dcl: RST_DUTY_LOW,
    dch: RST_DUTY_HIGH,
    pin_dir: RST_PIN_DIR,
    pin_sel: RST_PIN_SEL,
    sts: 1'b0,
    msk: 1'b0,
    div: 2'h0,
    lvl_prev: 1'b0,
    on_sh: 2'h0,
    pend: 1'b0,
    duty_sh: 10'h000,
    pwm_state: 1'b0,
    wrap_d: 1'b0,
    pin_val: 1'b0,
    irq: 1'b0
  };

  pwmpt_state_t st_ff;
  pwmpt_state_t nxt_st;

  logic [1:0] pins_s;
  logic sleep_s;
  logic ext_s;
  logic bus_wr;
  logic bus_rd;
  logic if_tick;
  logic lvl;
  logic clk_tick;
  logic tmr_run;
  logic pre_tick;
  logic pre_clr;
  logic pre_pulse;
  logic [1:0] pre_frac;
  logic inc;
  logic wrap;
  logic [9:0] duty_now;
  logic [31:0] rd_mux;
  logic rd_hit;

  pwmpt_sync2 #(
    .W(2)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({sleep_req, ext_clk_in}),
    .sync_out(pins_s)
  );

  assign sleep_s = pins_s[1];
  assign ext_s = pins_s[0];

  // Writes take effect in the access phase; read data is captured in setup so it comes from a flop.
  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // Instruction clock is a divide-by-four of pclk; with clk_src selecting the internal source the PWM rate scales with it.
  assign if_tick = !sleep_s && (st_ff.div == INSTR_DIV_LAST);
  assign lvl = st_ff.clk_src ? ext_s : st_ff.div[1];
  assign clk_tick = !sleep_s && (st_ff.hlt[HL_CLOCK_EDGE_SELECT_BIT] ? (st_ff.lvl_prev && !lvl) : (!st_ff.lvl_prev && lvl));

  // Enable either passes directly or through two timer-clock stages for glitch-free start and stop.
  assign tmr_run = st_ff.hlt[HL_ON_BIT_SYNC_ENABLE_BIT] ? st_ff.on_sh[1] : st_ff.tmr_on;
  assign pre_tick = clk_tick && tmr_run;
  assign pre_clr = bus_wr && ((paddr == ADDR_TIMER_COUNT) || (paddr == ADDR_TIMER_CTRL));

  pwmpt_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .tick(pre_tick),
    .clear(pre_clr),
    .sel(st_ff.prescale_select),
    .pulse(pre_pulse),
    .frac(pre_frac)
  );

  // A retimed pulse waits for the instruction clock, which stops in Sleep, so the timer cannot run there.
  assign inc = st_ff.hlt[HL_PRESCALER_SYNC_ENABLE_BIT] ? ((st_ff.pend || pre_pulse) && if_tick) : pre_pulse;
  assign wrap = inc && (st_ff.count == st_ff.period);
  assign duty_now = {st_ff.dch, st_ff.dcl};

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_TIMER_CTRL: begin
        rd_mux[TC_ON_BIT] = st_ff.tmr_on;
        rd_mux[TC_PRESCALE_SELECT_LSB +: 3] = st_ff.prescale_select;
        rd_mux[TC_SRC_BIT] = st_ff.clk_src;
      end
      ADDR_HW_LIMIT: begin
        rd_mux[7:0] = st_ff.hlt;
      end
      ADDR_TIMER_COUNT: begin
        rd_mux[7:0] = st_ff.count;
      end
      ADDR_PERIOD: begin
        rd_mux[7:0] = st_ff.period;
      end
      ADDR_WAVE_CTRL: begin
        rd_mux[WC_EN_BIT] = st_ff.pwm_en;
        rd_mux[WC_OUT_BIT] = st_ff.pwm_state ^ st_ff.pwm_pol;
        rd_mux[WC_POL_BIT] = st_ff.pwm_pol;
      end
      ADDR_DUTY_LOW: begin
        rd_mux[7:6] = st_ff.dcl;
      end
      ADDR_DUTY_HIGH: begin
        rd_mux[7:0] = st_ff.dch;
      end
      ADDR_PIN_CTRL: begin
        rd_mux[PC_DIR_BIT] = st_ff.pin_dir;
        rd_mux[PC_SEL_LSB +: 6] = st_ff.pin_sel;
      end
      ADDR_IRQ_STATUS: begin
        rd_mux[0] = st_ff.sts;
      end
      ADDR_IRQ_MASK: begin
        rd_mux[0] = st_ff.msk;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;

    if (psel && !penable) begin
      nxt_st.rdata = bus_rd ? rd_mux : 32'h0000_0000;
      nxt_st.slverr = !rd_hit;
    end

    // Timer, prescaler phase and waveform all stand still in Sleep and carry on from there after.
    if (!sleep_s) begin
      nxt_st.div = 2'(st_ff.div + 2'h1);
      nxt_st.lvl_prev = lvl;
      if (clk_tick) begin
        nxt_st.on_sh = {st_ff.on_sh[0], st_ff.tmr_on};
      end
      if (st_ff.hlt[HL_PRESCALER_SYNC_ENABLE_BIT]) begin
        nxt_st.pend = (st_ff.pend || pre_pulse) && !if_tick;
      end else begin
        nxt_st.pend = 1'b0;
      end
      if (wrap) begin
        nxt_st.count = 8'h00;
        if (st_ff.hlt[4:0] == MODE_ONE_SHOT) begin
          nxt_st.tmr_on = 1'b0;
        end
      end else if (inc) begin
        nxt_st.count = 8'(st_ff.count + 8'h01);
      end

      // Duty is taken into a shadow at each period start so a mid-period write cannot tear a pulse.
      if (!st_ff.pwm_en || wrap) begin
        nxt_st.duty_sh = duty_now;
      end
      // The rise waits one pclk after the wrap, matching the registered delay of the fall, so the high time is exact.
      nxt_st.wrap_d = wrap;
      if (!st_ff.pwm_en) begin
        nxt_st.pwm_state = 1'b0;
      end else if (st_ff.wrap_d) begin
        nxt_st.pwm_state = (st_ff.duty_sh != 10'h000);
      end else if ({st_ff.count, pre_frac} >= st_ff.duty_sh) begin
        nxt_st.pwm_state = 1'b0;
      end
      nxt_st.pin_val = (st_ff.pin_sel == PIN_ROUTE_PWM) && (st_ff.pwm_state ^ st_ff.pwm_pol);
    end

    if (bus_wr) begin
      case (paddr)
        ADDR_TIMER_CTRL: begin
          nxt_st.tmr_on = pwdata[TC_ON_BIT];
          nxt_st.prescale_select = pwdata[TC_PRESCALE_SELECT_LSB +: 3];
          nxt_st.clk_src = pwdata[TC_SRC_BIT];
        end
        ADDR_HW_LIMIT: begin
          nxt_st.hlt = pwdata[7:0];
        end
        ADDR_TIMER_COUNT: begin
          nxt_st.count = pwdata[7:0];
        end
        ADDR_PERIOD: begin
          nxt_st.period = pwdata[7:0];
        end
        ADDR_WAVE_CTRL: begin
          nxt_st.pwm_en = pwdata[WC_EN_BIT];
          nxt_st.pwm_pol = pwdata[WC_POL_BIT];
        end
        ADDR_DUTY_LOW: begin
          nxt_st.dcl = pwdata[7:6];
        end
        ADDR_DUTY_HIGH: begin
          nxt_st.dch = pwdata[7:0];
        end
        ADDR_PIN_CTRL: begin
          nxt_st.pin_dir = pwdata[PC_DIR_BIT];
          nxt_st.pin_sel = pwdata[PC_SEL_LSB +: 6];
        end
        ADDR_IRQ_STATUS: begin
          nxt_st.sts = st_ff.sts && !pwdata[0];
        end
        ADDR_IRQ_MASK: begin
          nxt_st.msk = pwdata[0];
        end
        default: begin
          nxt_st.sts = nxt_st.sts;
        end
      endcase
    end

    // Placed after the write-one-to-clear so a match in the clearing cycle is kept.
    if (wrap && !sleep_s) begin
      nxt_st.sts = 1'b1;
    end
    nxt_st.irq = nxt_st.sts && nxt_st.msk;
  end

  // Async reset returns every register to its reset value and the pin to input.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pslverr = st_ff.slverr && psel && penable;
  assign pwm_pin_out = st_ff.pin_val;
  assign pwm_pin_oe_n = st_ff.pin_dir;
  assign irq = st_ff.irq;

endmodule : pwmpt_top
`default_nettype wire

// ### test/pwmpt_load.sv
// Load model that measures pulse width and period on the driven pin.
`timescale 1ns/1ns
`default_nettype none
module pwmpt_load (
  input wire logic pclk,
  input wire logic pin,
  input wire logic oe_n,
  output int hi_len,
  output int per_len
);
  int run_hi = 0;
  int run_per = 0;
  logic last = 1'b0;
  logic lvl;
  // An undriven pin counts as low, since nothing pulls it.
  assign lvl = !oe_n && pin;
  initial begin
    hi_len = 0;
    per_len = 0;
  end
  always @(posedge pclk) begin
    last <= lvl;
    if (lvl && !last) begin
      per_len <= run_per;
      run_per <= 1;
      run_hi <= 1;
    end else begin
      run_per <= run_per + 1;
      if (lvl) run_hi <= run_hi + 1;
      if (!lvl && last) hi_len <= run_hi;
    end
  end
endmodule : pwmpt_load
`default_nettype wire

// ### test/pwmpt_sva.sv
// Port-level assertions for the PWM period timer block.
`timescale 1ns/1ns
`default_nettype none
module pwmpt_sva import pwmpt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_req,
  input wire logic ext_clk_in,
  input wire logic pwm_pin_out,
  input wire logic pwm_pin_oe_n,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready) else $error("pready low");
  err_gate_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  mapped_ok_a: assert property (psel && penable && paddr <= ADDR_IRQ_MASK && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr on mapped address");
  unmapped_rd_a: assert property (psel && !penable && !pwrite && paddr > ADDR_IRQ_MASK |=> prdata == 32'h0 && pslverr)
    else $error("unmapped read not refused");
  reset_out_a: assert property ($rose(presetn) |-> pwm_pin_oe_n && !pwm_pin_out && !irq)
    else $error("outputs not at reset level");
  sleep_hold_a: assert property (sleep_req [*5] |=> $stable(pwm_pin_out))
    else $error("pin moved in sleep");
  mask_off_a: assert property (psel && penable && pwrite && paddr == ADDR_IRQ_MASK && !pwdata[0] |=> !irq)
    else $error("irq high while masked");
  pin_on_a: assert property (psel && penable && pwrite && paddr == ADDR_PIN_CTRL && !pwdata[0] |-> ##2 !pwm_pin_oe_n)
    else $error("pin driver not enabled");
endmodule : pwmpt_sva
bind pwmpt_top pwmpt_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
  .ext_clk_in(ext_clk_in), .pwm_pin_out(pwm_pin_out), .pwm_pin_oe_n(pwm_pin_oe_n), .irq(irq));
`default_nettype wire

// ### test/pwmpt_top_test.sv
// Register-level test sequence for the PWM period timer block.
`timescale 1ns/1ns
`default_nettype none
module pwmpt_top_test import pwmpt_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, sleep_req, ext_clk_in, pwm_pin_out, pwm_pin_oe_n, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, a;
  int fails = 0;
  int check_count = 0;
  int hi_len, per_len, n;
  localparam logic [11:0] RA [10] = '{ADDR_TIMER_CTRL, ADDR_HW_LIMIT, ADDR_TIMER_COUNT, ADDR_PERIOD, ADDR_WAVE_CTRL,
    ADDR_DUTY_LOW, ADDR_DUTY_HIGH, ADDR_PIN_CTRL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  localparam logic [31:0] RV [10] = '{32'h0, 32'h0, 32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
  // Period 3 and duty {0, 2'b11} with prescale 1: four pclk per count.
  localparam int PER = 3;
  localparam int DUTY = 3;
  pwmpt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req),
    .ext_clk_in(ext_clk_in), .pwm_pin_out(pwm_pin_out), .pwm_pin_oe_n(pwm_pin_oe_n), .irq(irq));
  pwmpt_load i_load (.pclk(pclk), .pin(pwm_pin_out), .oe_n(pwm_pin_oe_n), .hi_len(hi_len), .per_len(per_len));
  initial forever #20 pclk = ~pclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic [11:0] ad, input logic wr, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    #(40 * 20000);
    fails++;
    give_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_req, ext_clk_in} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(RA[i], 1'b0, 32'h0);
      check("reset value", q, RV[i]);
    end
    check("pin direction", 32'(pwm_pin_oe_n), 32'h1);
    apb(12'h028, 1'b0, 32'h0);
    check("unmapped error", 32'(e), 32'h1);
    check("unmapped read", q, 32'h0);
    // Setup order keeps the first pulse complete.
    apb(ADDR_PIN_CTRL, 1'b1, 32'h1);
    apb(ADDR_WAVE_CTRL, 1'b1, 32'h0);
    apb(ADDR_PERIOD, 1'b1, PER);
    apb(ADDR_DUTY_HIGH, 1'b1, DUTY >> 2);
    apb(ADDR_DUTY_LOW, 1'b1, (DUTY & 3) << 6);
    apb(ADDR_IRQ_STATUS, 1'b1, 32'h1);
    apb(ADDR_TIMER_CTRL, 1'b1, 32'h80);
    n = 0;
    do begin
      apb(ADDR_IRQ_STATUS, 1'b0, 32'h0);
      n++;
    end while (q[0] !== 1'b1 && n < 50);
    check("period flag", q, 32'h1);
    check("irq unmasked off", 32'(irq), 32'h0);
    apb(ADDR_IRQ_MASK, 1'b1, 32'h1);
    @(negedge pclk);
    check("irq", 32'(irq), 32'h1);
    apb(ADDR_PIN_CTRL, 1'b1, {18'h0, PIN_ROUTE_PWM, 8'h0});
    apb(ADDR_WAVE_CTRL, 1'b1, 32'h80);
    repeat (100) @(posedge pclk);
    check("high time", hi_len, ((DUTY + 3) / 4) * 4);
    check("period", per_len, (PER + 1) * 4);
    apb(ADDR_WAVE_CTRL, 1'b1, 32'h90);
    repeat (100) @(posedge pclk);
    check("inverted high", hi_len, (PER + 1) * 4 - ((DUTY + 3) / 4) * 4);
    // Prescale 4 steps the ten-bit value once per timer tick, four pclk apart.
    apb(ADDR_WAVE_CTRL, 1'b1, 32'h80);
    apb(ADDR_TIMER_CTRL, 1'b1, 32'ha0);
    repeat (200) @(posedge pclk);
    check("prescaled high", hi_len, DUTY * 4);
    check("prescaled period", per_len, (PER + 1) * 16);
    apb(ADDR_TIMER_CTRL, 1'b1, 32'h0);
    repeat (20) @(posedge pclk);
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    a = q;
    repeat (40) @(posedge pclk);
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("stopped count", q, a);
    apb(ADDR_IRQ_STATUS, 1'b1, 32'h1);
    @(negedge pclk);
    check("irq cleared", 32'(irq), 32'h0);
    apb(ADDR_HW_LIMIT, 1'b1, {27'h0, MODE_ONE_SHOT});
    apb(ADDR_TIMER_CTRL, 1'b1, 32'h80);
    repeat (60) @(posedge pclk);
    apb(ADDR_TIMER_CTRL, 1'b0, 32'h0);
    check("one shot stop", q, 32'h0);
    apb(ADDR_IRQ_STATUS, 1'b0, 32'h0);
    check("one shot flag", q, 32'h1);
    apb(ADDR_TIMER_COUNT, 1'b1, 32'h0);
    apb(ADDR_HW_LIMIT, 1'b1, 32'h20);
    apb(ADDR_TIMER_CTRL, 1'b1, 32'h80);
    // Without the synced start the first count would already have landed.
    repeat (5) @(posedge pclk);
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("synced start", q, 32'h0);
    apb(ADDR_PERIOD, 1'b1, 32'hff);
    apb(ADDR_HW_LIMIT, 1'b1, 32'ha0);
    repeat (200) @(posedge pclk);
    sleep_req <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    a = q;
    repeat (40) @(posedge pclk);
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("sleep count", q, a);
    sleep_req <= 1'b0;
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("count resumed", 32'(q >= a && q <= a + 3 && a > 8), 32'h1);
    repeat (40) @(posedge pclk);
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("count advancing", 32'(q > a && q <= a + 15), 32'h1);
    // External clock on the falling edge: five toggles from low hold two falling edges, three rising.
    apb(ADDR_TIMER_CTRL, 1'b1, 32'h1);
    apb(ADDR_HW_LIMIT, 1'b1, 32'h40);
    apb(ADDR_TIMER_COUNT, 1'b1, 32'h0);
    apb(ADDR_TIMER_CTRL, 1'b1, 32'h81);
    for (int i = 0; i < 5; i++) begin
      repeat (4) @(posedge pclk);
      ext_clk_in <= !ext_clk_in;
    end
    repeat (6) @(posedge pclk);
    apb(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("falling edge count", q, 32'h2);
    apb(ADDR_IRQ_MASK, 1'b1, 32'h0);
    @(negedge pclk);
    check("irq masked", 32'(irq), 32'h0);
    // A reset in mid-run must bring every register back and release the pin.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      apb(RA[i], 1'b0, 32'h0);
      check("value after reset", q, RV[i]);
    end
    check("pin released", 32'(pwm_pin_oe_n), 32'h1);
    check("pin low", 32'(pwm_pin_out), 32'h0);
    give_verdict();
  end
endmodule : pwmpt_top_test
`default_nettype wire
